// ==== pkg/ccp_cfg.svh ====
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// Register indices; byte address is four times the index
`define CCP_IDX_FLAGS1   10'h00C
`define CCP_IDX_FLAGS2   10'h00D
`define CCP_IDX_T1_LO    10'h00E
`define CCP_IDX_T1_HI    10'h00F
`define CCP_IDX_T1_CON   10'h010
`define CCP_IDX_T2_CNT   10'h011
`define CCP_IDX_T2_CON   10'h012
`define CCP_IDX_U1_LO    10'h015
`define CCP_IDX_U1_HI    10'h016
`define CCP_IDX_U1_CON   10'h017
`define CCP_IDX_U2_LO    10'h01B
`define CCP_IDX_U2_HI    10'h01C
`define CCP_IDX_U2_CON   10'h01D
`define CCP_IDX_ENABLES1 10'h08C
`define CCP_IDX_ENABLES2 10'h08D
`define CCP_IDX_T2_PER   10'h092

// Field positions
`define CCP_FLAG1_UNIT1  2
`define CCP_FLAG1_T1OVF  0
`define CCP_FLAG2_UNIT2  0
`define CCP_T1_ON        0
`define CCP_T1_PS_LO     4
`define CCP_T2_PS_LO     0
`define CCP_T2_ON        2
`define CCP_CON_DUTY_LO  4

// Reset values
`define CCP_RST_BYTE     8'h00
`define CCP_RST_T2_PER   8'hFF

// Timing: oscillator periods per instruction cycle
`define CCP_TOSC_PER_INSTR 4

`endif

// ==== pkg/ccp_pkg.sv ====
package ccp_pkg;

    // Decoded function of one unit
    typedef enum logic [2:0] {
        UNIT_OFF,
        UNIT_CAPTURE,
        CMP_SET_PIN,
        CMP_CLEAR_PIN,
        CMP_FLAG_ONLY,
        CMP_SPECIAL,
        UNIT_PWM
    } unit_mode_t;

    // Mode field decode; reserved codes act as off
    function automatic unit_mode_t decode_mode(input logic [3:0] m);
        unit_mode_t r;
        r = UNIT_OFF;
        casez (m)
            4'b01??: r = UNIT_CAPTURE;
            4'b1000: r = CMP_SET_PIN;
            4'b1001: r = CMP_CLEAR_PIN;
            4'b1010: r = CMP_FLAG_ONLY;
            4'b1011: r = CMP_SPECIAL;
            4'b11??: r = UNIT_PWM;
            default: r = UNIT_OFF;
        endcase
        return r;
    endfunction : decode_mode

endpackage : ccp_pkg

// ==== hdl/ccp_compare_and_pwm.sv ====
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_compare_and_pwm (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_adc_enabled,
    output logic             o_adc_start,
    output logic             o_unit_one_pin,
    output logic             o_unit_two_pin,
    output logic             o_irq_request
);
    import ccp_pkg::*;

    localparam int UNITS = 2;

    // Instruction-cycle phase counter
    logic [1:0] qph_q;
    logic       instr_tick;
    assign instr_tick = (qph_q == 2'(`CCP_TOSC_PER_INSTR - 1));

    always_ff @(posedge i_clk) begin
        if (i_reset || instr_tick) begin
            qph_q <= 2'h0;
        end else begin
            qph_q <= qph_q + 2'h1;
        end
    end

    // APB address decode
    logic [9:0] idx;
    logic       aligned;
    logic       wr;
    logic [7:0] wd;
    assign idx     = i_paddr[11:2];
    assign aligned = (i_paddr[1:0] == 2'h0);
    assign wr      = i_psel && i_penable && i_pwrite;
    assign wd      = i_pwdata[7:0];

    logic hit_f1, hit_f2, hit_t1l, hit_t1h, hit_t1c, hit_t2, hit_t2c;
    logic hit_e1, hit_e2, hit_pr;
    logic hit_lo  [UNITS];
    logic hit_hi  [UNITS];
    logic hit_con [UNITS];
    logic mapped;
    assign hit_f1     = aligned && (idx == `CCP_IDX_FLAGS1);
    assign hit_f2     = aligned && (idx == `CCP_IDX_FLAGS2);
    assign hit_t1l    = aligned && (idx == `CCP_IDX_T1_LO);
    assign hit_t1h    = aligned && (idx == `CCP_IDX_T1_HI);
    assign hit_t1c    = aligned && (idx == `CCP_IDX_T1_CON);
    assign hit_t2     = aligned && (idx == `CCP_IDX_T2_CNT);
    assign hit_t2c    = aligned && (idx == `CCP_IDX_T2_CON);
    assign hit_e1     = aligned && (idx == `CCP_IDX_ENABLES1);
    assign hit_e2     = aligned && (idx == `CCP_IDX_ENABLES2);
    assign hit_pr     = aligned && (idx == `CCP_IDX_T2_PER);
    assign hit_lo[0]  = aligned && (idx == `CCP_IDX_U1_LO);
    assign hit_hi[0]  = aligned && (idx == `CCP_IDX_U1_HI);
    assign hit_con[0] = aligned && (idx == `CCP_IDX_U1_CON);
    assign hit_lo[1]  = aligned && (idx == `CCP_IDX_U2_LO);
    assign hit_hi[1]  = aligned && (idx == `CCP_IDX_U2_HI);
    assign hit_con[1] = aligned && (idx == `CCP_IDX_U2_CON);
    assign mapped = hit_f1 || hit_f2 || hit_t1l || hit_t1h || hit_t1c
                 || hit_t2 || hit_t2c || hit_e1 || hit_e2 || hit_pr
                 || hit_lo[0] || hit_hi[0] || hit_con[0]
                 || hit_lo[1] || hit_hi[1] || hit_con[1];

    // Zero-wait slave; unmapped access errors out
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // Per-unit state
    logic [7:0] val_lo_q  [UNITS];
    logic [7:0] val_hi_q  [UNITS];
    logic [5:0] con_q     [UNITS];
    logic [1:0] lsb_act_q [UNITS];
    logic       pin_q     [UNITS];
    logic       flag_q    [UNITS];
    logic       ien_q     [UNITS];
    logic       eq_q      [UNITS];
    unit_mode_t mode      [UNITS];
    logic       match     [UNITS];
    logic       special   [UNITS];
    logic       pwm_clear [UNITS];
    logic       flag_wr   [UNITS];
    logic       flag_wbit [UNITS];

    assign flag_wr[0]   = wr && hit_f1;
    assign flag_wr[1]   = wr && hit_f2;
    assign flag_wbit[0] = wd[`CCP_FLAG1_UNIT1];
    assign flag_wbit[1] = wd[`CCP_FLAG2_UNIT2];

    // Timer1 registers
    logic [15:0] t1_q;
    logic [5:0]  timer_one_control_q;
    logic [2:0]  t1pre_q;
    logic [2:0]  t1_mask;
    logic [1:0]  t1_ps;
    logic        t1_on;
    logic        t1_tick;
    logic        t1ovf_q;
    logic        t1ovf_en_q;
    logic        event_reset;
    assign t1_ps   = timer_one_control_q[`CCP_T1_PS_LO +: 2];
    assign t1_on   = timer_one_control_q[`CCP_T1_ON];
    assign t1_mask = {t1_ps == 2'h3, t1_ps[1], t1_ps != 2'h0};
    assign t1_tick = instr_tick && t1_on && (t1pre_q == t1_mask);
    assign event_reset = special[0] || special[1];

    // Timer1 prescaler over instruction cycles
    always_ff @(posedge i_clk) begin
        if (i_reset || !t1_on || event_reset) begin
            t1pre_q <= 3'h0;
        end else if (instr_tick) begin
            t1pre_q <= (t1pre_q == t1_mask) ? 3'h0 : t1pre_q + 3'h1;
        end
    end

    // Timer1 count; software write beats the event clear
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            t1_q <= 16'h0000;
        end else if (wr && hit_t1l) begin
            t1_q[7:0] <= wd;
        end else if (wr && hit_t1h) begin
            t1_q[15:8] <= wd;
        end else if (event_reset) begin
            t1_q <= 16'h0000;
        end else if (t1_tick) begin
            t1_q <= t1_q + 16'h0001;
        end
    end

    // Overflow flag only from a real wrap; set wins over clear
    logic t1_wrap;
    assign t1_wrap = t1_tick && (t1_q == 16'hFFFF) && !event_reset
                  && !(wr && (hit_t1l || hit_t1h));

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            t1ovf_q    <= 1'b0;
            t1ovf_en_q <= 1'b0;
            timer_one_control_q    <= 6'h00;
        end else begin
            if (t1_wrap) begin
                t1ovf_q <= 1'b1;
            end else if (wr && hit_f1) begin
                t1ovf_q <= wd[`CCP_FLAG1_T1OVF];
            end
            if (wr && hit_e1) begin
                t1ovf_en_q <= wd[`CCP_FLAG1_T1OVF];
            end
            if (wr && hit_t1c) begin
                timer_one_control_q <= wd[5:0];
            end
        end
    end

    // Timer2 and period register
    logic [7:0] t2_q;
    logic [7:0] pr2_q;
    logic [6:0] timer_two_control_q;
    logic [3:0] pre2_q;
    logic [3:0] pre2_term;
    logic [1:0] t2_ps;
    logic [1:0] t2_frac;
    logic [9:0] t2_ext;
    logic       t2_tick;
    logic       period_start;
    assign t2_ps     = timer_two_control_q[`CCP_T2_PS_LO +: 2];
    assign pre2_term = t2_ps[1] ? 4'hF : (t2_ps[0] ? 4'h3 : 4'h0);
    assign t2_tick   = instr_tick && timer_two_control_q[`CCP_T2_ON]
                    && (pre2_q == pre2_term);
    // Period match; postscaler bits 6:3 are stored only
    assign period_start = t2_tick && (t2_q == pr2_q);

    // Pin set trails period start by one cycle, so high time equals duty
    logic pwm_start_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pwm_start_q <= 1'b0;
        end else begin
            pwm_start_q <= period_start;
        end
    end

    // Fractional bits: phase counter at 1:1, prescaler bits otherwise
    assign t2_frac = t2_ps[1] ? pre2_q[3:2]
                   : (t2_ps[0] ? pre2_q[1:0] : qph_q);
    assign t2_ext  = {t2_q, t2_frac};

    // Timer2 prescaler; a count or control write restarts it
    always_ff @(posedge i_clk) begin
        if (i_reset || !timer_two_control_q[`CCP_T2_ON]
            || (wr && (hit_t2 || hit_t2c))) begin
            pre2_q <= 4'h0;
        end else if (instr_tick) begin
            pre2_q <= (pre2_q == pre2_term) ? 4'h0 : pre2_q + 4'h1;
        end
    end

    // Timer2 count wraps after reaching the period value
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            t2_q    <= `CCP_RST_BYTE;
            pr2_q   <= `CCP_RST_T2_PER;
            timer_two_control_q <= 7'h00;
        end else begin
            if (wr && hit_t2) begin
                t2_q <= wd;
            end else if (period_start) begin
                t2_q <= `CCP_RST_BYTE;
            end else if (t2_tick) begin
                t2_q <= t2_q + 8'h01;
            end
            if (wr && hit_pr) begin
                pr2_q <= wd;
            end
            if (wr && hit_t2c) begin
                timer_two_control_q <= wd[6:0];
            end
        end
    end

    // One slice per unit
    genvar u;
    for (u = 0; u < UNITS; u++) begin : g_unit
        logic       eq;
        logic       is_cmp;
        logic       con_zero;
        logic [9:0] duty_act;
        assign mode[u]   = decode_mode(con_q[u][3:0]);
        assign is_cmp    = (mode[u] == CMP_SET_PIN)
                        || (mode[u] == CMP_CLEAR_PIN)
                        || (mode[u] == CMP_FLAG_ONLY)
                        || (mode[u] == CMP_SPECIAL);
        // Equality every cycle; act on its first cycle only
        assign eq        = is_cmp
                        && ({val_hi_q[u], val_lo_q[u]} == t1_q);
        assign match[u]  = eq && !eq_q[u];
        assign special[u] = match[u] && (mode[u] == CMP_SPECIAL);
        assign duty_act  = {val_hi_q[u], lsb_act_q[u]};
        // Never true when duty lies beyond the period
        assign pwm_clear[u] = (mode[u] == UNIT_PWM)
                           && (duty_act == t2_ext);
        assign con_zero  = wr && hit_con[u] && (wd == 8'h00);

        // Match edge tracker
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                eq_q[u] <= 1'b0;
            end else begin
                eq_q[u] <= eq;
            end
        end

        // Value and control; high byte is hardware-owned in PWM
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                val_lo_q[u] <= `CCP_RST_BYTE;
                val_hi_q[u] <= `CCP_RST_BYTE;
                con_q[u]    <= 6'h00;
            end else begin
                if (wr && hit_lo[u]) begin
                    val_lo_q[u] <= wd;
                end
                if (mode[u] == UNIT_PWM) begin
                    if (period_start) begin
                        val_hi_q[u] <= val_lo_q[u];
                    end
                end else if (wr && hit_hi[u]) begin
                    val_hi_q[u] <= wd;
                end
                if (wr && hit_con[u]) begin
                    con_q[u] <= wd[5:0];
                end
            end
        end

        // Hidden 2-bit duty latch
        always_ff @(posedge i_clk) begin
            if (i_reset || con_zero) begin
                lsb_act_q[u] <= 2'h0;
            end else if (period_start && mode[u] == UNIT_PWM) begin
                lsb_act_q[u] <= con_q[u][`CCP_CON_DUTY_LO +: 2];
            end
        end

        // Output latch; period start outranks the duty clear
        always_ff @(posedge i_clk) begin
            if (i_reset || con_zero) begin
                pin_q[u] <= 1'b0;
            end else begin
                case (mode[u])
                    UNIT_OFF: begin
                        pin_q[u] <= 1'b0;
                    end
                    CMP_SET_PIN: begin
                        if (match[u]) begin
                            pin_q[u] <= 1'b1;
                        end
                    end
                    CMP_CLEAR_PIN: begin
                        if (match[u]) begin
                            pin_q[u] <= 1'b0;
                        end
                    end
                    UNIT_PWM: begin
                        if (pwm_start_q) begin
                            pin_q[u] <= (duty_act != 10'h000);
                        end else if (pwm_clear[u]) begin
                            pin_q[u] <= 1'b0;
                        end
                    end
                    default: begin
                        pin_q[u] <= pin_q[u];
                    end
                endcase
            end
        end

        // Match flag and its enable; set wins over a clearing write
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                flag_q[u] <= 1'b0;
                ien_q[u]  <= 1'b0;
            end else begin
                if (match[u]) begin
                    flag_q[u] <= 1'b1;
                end else if (flag_wr[u]) begin
                    flag_q[u] <= flag_wbit[u];
                end
                if (wr && ((u == 0) ? hit_e1 : hit_e2)) begin
                    ien_q[u] <= flag_wbit[u];
                end
            end
        end
    end

    // Pins, converter start and combined request
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_adc_start   <= 1'b0;
            o_irq_request <= 1'b0;
        end else begin
            o_adc_start   <= special[1] && i_adc_enabled;
            o_irq_request <= (flag_q[0] && ien_q[0])
                          || (flag_q[1] && ien_q[1])
                          || (t1ovf_q && t1ovf_en_q);
        end
    end
    assign o_unit_one_pin = pin_q[0];
    assign o_unit_two_pin = pin_q[1];

    // Read mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_f1) begin
            rd_byte[`CCP_FLAG1_UNIT1] = flag_q[0];
            rd_byte[`CCP_FLAG1_T1OVF] = t1ovf_q;
        end else if (hit_f2) begin
            rd_byte[`CCP_FLAG2_UNIT2] = flag_q[1];
        end else if (hit_e1) begin
            rd_byte[`CCP_FLAG1_UNIT1] = ien_q[0];
            rd_byte[`CCP_FLAG1_T1OVF] = t1ovf_en_q;
        end else if (hit_e2) begin
            rd_byte[`CCP_FLAG2_UNIT2] = ien_q[1];
        end else if (hit_t1l) begin
            rd_byte = t1_q[7:0];
        end else if (hit_t1h) begin
            rd_byte = t1_q[15:8];
        end else if (hit_t1c) begin
            rd_byte = {2'h0, timer_one_control_q};
        end else if (hit_t2) begin
            rd_byte = t2_q;
        end else if (hit_t2c) begin
            rd_byte = {1'b0, timer_two_control_q};
        end else if (hit_pr) begin
            rd_byte = pr2_q;
        end else if (hit_lo[0]) begin
            rd_byte = val_lo_q[0];
        end else if (hit_hi[0]) begin
            rd_byte = val_hi_q[0];
        end else if (hit_con[0]) begin
            rd_byte = {2'h0, con_q[0]};
        end else if (hit_lo[1]) begin
            rd_byte = val_lo_q[1];
        end else if (hit_hi[1]) begin
            rd_byte = val_hi_q[1];
        end else if (hit_con[1]) begin
            rd_byte = {2'h0, con_q[1]};
        end
    end

    // Read data caught in the setup cycle, stable through access
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule : ccp_compare_and_pwm

// ==== verification/adc_partner.sv ====
`timescale 1ns/1ps

// Converter stand-in: enable level and a tally of start requests
module adc_partner (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_power,
    input  wire logic i_start,
    output logic      o_enabled,
    output int        o_starts,
    output int        o_stray
);
    // Level the block saw when it launched the start now arriving
    logic en_q;

    // Enable lags power by a cycle, like a control bit behind a write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_enabled <= 1'b0;
            en_q      <= 1'b0;
            o_starts  <= 0;
            o_stray   <= 0;
        end else begin
            o_enabled <= i_power;
            en_q      <= o_enabled;
            if (i_start) begin
                o_starts <= o_starts + 1;
            end
            // A start while the converter was off is counted as stray
            if (i_start && !en_q) begin
                o_stray <= o_stray + 1;
            end
        end
    end
endmodule : adc_partner

// ==== verification/ccp_assertions.sv ====
`timescale 1ns/1ps
`include "ccp_cfg.svh"

// Port-level checks of the bus and the unit outputs
module ccp_assertions (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_adc_enabled,
    input wire logic        o_adc_start,
    input wire logic        o_unit_one_pin,
    input wire logic        o_unit_two_pin,
    input wire logic        o_irq_request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Access phase writing zero to the unit one control register
    sequence s_con_zero;
        i_psel && i_penable && i_pwrite && i_pwdata[7:0] == 8'h00
            && i_paddr == {`CCP_IDX_U1_CON, 2'b00};
    endsequence
    // Finished read followed by an idle cycle
    sequence s_read_idle;
        i_psel && i_penable && !i_pwrite ##1 !i_psel;
    endsequence

    AST_PREADY: assert property (o_pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("pslverr outside access");
    AST_ERR_ALIGN: assert property
        (i_psel && i_penable && i_paddr[1:0] != 2'b00 |-> o_pslverr)
        else $error("unaligned access not refused");
    AST_UPPER_ZERO: assert property (o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_READ_HOLD: assert property (s_read_idle |-> $stable(o_prdata))
        else $error("read data not held");
    AST_ADC_GATE: assert property (o_adc_start |-> $past(i_adc_enabled))
        else $error("start while converter off");
    AST_ADC_PULSE: assert property (o_adc_start |=> !o_adc_start)
        else $error("start longer than a cycle");
    AST_CON_ZERO: assert property (s_con_zero |-> ##[1:2] !o_unit_one_pin)
        else $error("pin not forced low");
    AST_RESET: assert property (disable iff (1'b0) i_reset |=>
        !o_unit_one_pin && !o_unit_two_pin && !o_adc_start && !o_irq_request)
        else $error("outputs not cleared by reset");
endmodule : ccp_assertions

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "ccp_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
    import ccp_pkg::*;
    logic        i_clk = 1'b0, i_reset = 1'b1, power = 1'b0;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic        o_pready, o_pslverr, i_adc_enabled, o_adc_start;
    logic        o_unit_one_pin, o_unit_two_pin, o_irq_request;
    int          n_mismatch = 0, compares = 0, cyc = 0, starts, stray;

    ccp_compare_and_pwm i_ccp_compare_and_pwm (.i_clk, .i_reset, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_adc_enabled, .o_adc_start, .o_unit_one_pin,
        .o_unit_two_pin, .o_irq_request);
    adc_partner i_adc_partner (.i_clk, .i_reset, .i_power(power),
        .i_start(o_adc_start), .o_enabled(i_adc_enabled),
        .o_starts(starts), .o_stray(stray));

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    // Ceiling well above the roughly 1300 cycles the run needs
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // One APB transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [7:0] d, output logic [31:0] r, output logic e);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [9:0] x, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, {x, 2'b00}, d, r, e);
    endtask : wr

    task automatic rd(input logic [9:0] x, input logic [7:0] v,
            input string nm);
        logic [31:0] r;
        logic e;
        xfer(1'b0, {x, 2'b00}, 8'h00, r, e);
        `CHK(nm, 32'(v), r)
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wt

    // Bounded wait for a unit one pin level, then judge it
    task automatic pin(input logic v, input string nm);
        int n;
        n = 0;
        while (o_unit_one_pin !== v && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        `CHK(nm, v, o_unit_one_pin)
    endtask : pin

    // Pin must keep one level for n cycles
    task automatic hold(input logic v, input int n, input string nm);
        logic s;
        s = v;
        repeat (n) begin
            @(posedge i_clk);
            if (o_unit_one_pin !== v) s = ~v;
        end
        `CHK(nm, v, s)
    endtask : hold

    // Restart Timer1 from zero with a new compare value and mode
    task automatic go(input logic [9:0] x, input logic [7:0] v,
            input logic [7:0] m);
        wr(`CCP_IDX_T1_CON, 8'h00);
        wr(`CCP_IDX_T1_LO, 8'h00);
        wr(`CCP_IDX_T1_HI, 8'h00);
        wr(x, v);
        wr(x + 10'h001, 8'h00);
        wr(x + 10'h002, m);
        wr(`CCP_IDX_T1_CON, 8'h01);
    endtask : go

    // One full PWM period: high cycles, then total cycles
    task automatic meas(output int hi, output int per);
        int n;
        n = 0;
        while (o_unit_one_pin !== 1'b0 && n < 600) begin
            @(posedge i_clk);
            n++;
        end
        while (o_unit_one_pin !== 1'b1 && n < 600) begin
            @(posedge i_clk);
            n++;
        end
        hi = 0;
        while (o_unit_one_pin === 1'b1 && hi < 300) begin
            hi++;
            @(posedge i_clk);
        end
        per = hi;
        while (o_unit_one_pin === 1'b0 && per < 300) begin
            per++;
            @(posedge i_clk);
        end
    endtask : meas

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(`CCP_IDX_U1_CON, 8'h00, "con1");
        rd(`CCP_IDX_FLAGS1, 8'h00, "flags1");
        rd(`CCP_IDX_T2_PER, 8'hFF, "period");
        xfer(1'b0, 12'h000, 8'h00, r, e);
        `CHK("unmapped", 1'b1, e)
        xfer(1'b1, 12'h059, 8'h01, r, e);
        `CHK("unaligned", 1'b1, e)
        $display("test reset done");
    endtask : t_reset

    task automatic t_cmp();
        go(`CCP_IDX_U1_LO, 8'h03, 8'h08);
        pin(1'b1, "set on match");
        rd(`CCP_IDX_FLAGS1, 8'h04, "flag");
        `CHK("irq masked", 1'b0, o_irq_request)
        wr(`CCP_IDX_ENABLES1, 8'h04);
        wt(2);
        `CHK("irq on", 1'b1, o_irq_request)
        wr(`CCP_IDX_FLAGS1, 8'h00);
        go(`CCP_IDX_U1_LO, 8'h04, 8'h0A);
        hold(1'b1, 40, "flag-only pin");
        rd(`CCP_IDX_FLAGS1, 8'h04, "flag-only");
        go(`CCP_IDX_U1_LO, 8'h02, 8'h09);
        pin(1'b0, "clear on match");
        go(`CCP_IDX_U1_LO, 8'h02, 8'h08);
        pin(1'b1, "set again");
        wr(`CCP_IDX_U1_CON, 8'h00);
        wt(2);
        `CHK("con zero", 1'b0, o_unit_one_pin)
        go(`CCP_IDX_U1_LO, 8'h02, 8'h04);
        hold(1'b0, 40, "capture pin");
        wr(`CCP_IDX_FLAGS1, 8'h00);
        wr(`CCP_IDX_ENABLES1, 8'h00);
        $display("test compare done");
    endtask : t_cmp

    task automatic t_evt();
        logic [31:0] r;
        logic e;
        int s;
        power <= 1'b1;
        go(`CCP_IDX_U2_LO, 8'h05, 8'h0B);
        wt(150);
        `CHK("starts", 1'b1, starts >= 3)
        `CHK("u2 pin", 1'b0, o_unit_two_pin)
        xfer(1'b0, {`CCP_IDX_T1_LO, 2'b00}, 8'h00, r, e);
        `CHK("t1 wraps", 1'b1, r[7:0] <= 8'h05)
        rd(`CCP_IDX_FLAGS1, 8'h00, "no ovf");
        rd(`CCP_IDX_FLAGS2, 8'h01, "flag2");
        power <= 1'b0;
        wt(3);
        s = starts;
        wt(100);
        `CHK("gated", s, starts)
        `CHK("stray", 0, stray)
        wr(`CCP_IDX_U2_CON, 8'h00);
        go(`CCP_IDX_U1_LO, 8'h02, 8'h0B);
        wt(60);
        xfer(1'b0, {`CCP_IDX_T1_LO, 2'b00}, 8'h00, r, e);
        `CHK("t1 period", 1'b1, r[7:0] <= 8'h02)
        rd(`CCP_IDX_FLAGS1, 8'h04, "unit1 no ovf");
        $display("test event done");
    endtask : t_evt

    task automatic t_pwm();
        int hi, per;
        wr(`CCP_IDX_T1_CON, 8'h00);
        wr(`CCP_IDX_T2_PER, 8'h07);
        wr(`CCP_IDX_U1_LO, 8'h00);
        wr(`CCP_IDX_U1_CON, 8'h20);
        wr(`CCP_IDX_T2_CON, 8'h04);
        wr(`CCP_IDX_U1_CON, 8'h2C);
        meas(hi, per);
        `CHK("high", 2, hi)
        `CHK("period", 32, per)
        wr(`CCP_IDX_T2_CON, 8'h7C);
        meas(hi, per);
        `CHK("postscale", 32, per)
        wr(`CCP_IDX_U1_LO, 8'h01);
        rd(`CCP_IDX_U1_HI, 8'h00, "duty held");
        wr(`CCP_IDX_T2_CON, 8'h05);
        meas(hi, per);
        `CHK("high ps4", 24, hi)
        `CHK("period ps4", 128, per)
        rd(`CCP_IDX_U1_HI, 8'h01, "duty loaded");
        wr(`CCP_IDX_U1_HI, 8'h55);
        rd(`CCP_IDX_U1_HI, 8'h01, "hi read-only");
        wr(`CCP_IDX_T2_CON, 8'h04);
        wr(`CCP_IDX_U1_LO, 8'h10);
        wt(40);
        hold(1'b1, 80, "over period");
        wr(`CCP_IDX_U1_CON, 8'h00);
        wt(2);
        `CHK("pwm con zero", 1'b0, o_unit_one_pin)
        wr(`CCP_IDX_U1_LO, 8'h00);
        wr(`CCP_IDX_U1_CON, 8'h0C);
        wt(40);
        hold(1'b0, 40, "zero duty");
        $display("test pwm done");
    endtask : t_pwm

    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_cmp();
        t_evt();
        t_pwm();
        end_sim();
    end
endmodule : tb

bind ccp_compare_and_pwm ccp_assertions i_ccp_assertions (.i_clk,
    .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_adc_enabled, .o_adc_start,
    .o_unit_one_pin, .o_unit_two_pin, .o_irq_request);
